// File: core/power_budget_capability_regs.sv
// Power budgeting capability register bank behind an AXI4-Lite slave
// Operation
// - Lockable 16-bit capability identifier, resets zero
// - Lockable 4-bit capability version, resets zero
// - Lockable 12-bit next pointer, zero ends list
// - Eight-bit read-write entry selector, resets zero
// - Selector above seven makes window read zero
// - Window shows entry chosen by selector
// - Lockable system allocated flag, resets zero
// - Eight sticky 32-bit entries at 0x300-0x31C
// - Entry writes accepted only while unlocked
// - Locked entries discard every write
`timescale 1ns/10ps
module power_budget_capability_regs #(
   parameter logic [11:0] NEXT_PTR_RESET = budget_pkg::NXT_END // Next pointer after reset
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [11:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [11:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic eeprom_wr_en, // Serial EEPROM loader write
   input wire logic [11:0] eeprom_addr, // Loader byte address
   input wire logic [31:0] eeprom_wdata // Loader full word
);
   budget_pkg::wr_state_t wr_state_reg, wr_state_next;
   budget_pkg::rd_state_t rd_state_reg, rd_state_next;
   budget_pkg::reg_sel_t wr_sel, ar_sel;

   logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic aw_fire, w_fire, b_fire, ar_fire, r_fire;
   logic bus_wr_go, wr_go, lock_ok, entry_wr_en;
   logic [11:0] wr_addr;
   logic [31:0] wr_data, wr_mask;
   logic [15:0] capability_identifier_reg;
   logic [3:0] capability_version_reg;
   logic [11:0] nxt_ptr_reg;
   logic [7:0] sel_reg;
   logic sa_reg, unlock_reg, lock_reg;
   logic [31:0] header_word, select_word, flags_word, switch_control_register_word, hdr_merged;
   logic [31:0] sel_merged, flags_merged, switch_control_register_merged;
   logic [31:0] win_data, window_word, entry_rd_data, rd_word;

   // Word address decode shared by both channels
   function automatic budget_pkg::reg_sel_t decode_reg(input logic [11:0] addr);
      decode_reg = budget_pkg::RS_NONE;
      if (addr[11:2] == budget_pkg::HEADER_OFFSET[11:2]) begin
         decode_reg = budget_pkg::RS_HEADER;
      end else if (addr[11:2] == budget_pkg::SELECT_OFFSET[11:2]) begin
         decode_reg = budget_pkg::RS_SELECT;
      end else if (addr[11:2] == budget_pkg::WINDOW_OFFSET[11:2]) begin
         decode_reg = budget_pkg::RS_WINDOW;
      end else if (addr[11:2] == budget_pkg::FLAGS_OFFSET[11:2]) begin
         decode_reg = budget_pkg::RS_FLAGS;
      end else if (addr[11:2] == budget_pkg::SWITCH_CONTROL_REGISTER_OFFSET[11:2]) begin
         decode_reg = budget_pkg::RS_SWITCH_CONTROL_REGISTER;
      end else if (addr[11:5] == budget_pkg::ENTRY_BASE[11:5]) begin
         decode_reg = budget_pkg::RS_ENTRY;
      end
   endfunction

   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         strb_mask[8*i +: 8] = {8{strb[i]}};
      end
   endfunction

   function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [31:0] mask);
      merge_word = (old_w & ~mask) | (new_w & mask);
   endfunction

   // Handshakes
   assign aw_fire = s_axi_awvalid && awready_reg;
   assign w_fire = s_axi_wvalid && wready_reg;
   assign b_fire = bvalid_reg && s_axi_bready;
   assign ar_fire = s_axi_arvalid && arready_reg;
   assign r_fire = rvalid_reg && s_axi_rready;

   // Loader has priority; a bus write waits for as long as the loader writes
   assign bus_wr_go = aw_held_reg && w_held_reg && !eeprom_wr_en &&
                      (wr_state_reg == budget_pkg::WR_COLLECT);
   assign wr_go = eeprom_wr_en || bus_wr_go;
   assign lock_ok = eeprom_wr_en || !lock_reg;

   always_comb begin
      if (eeprom_wr_en) begin
         wr_addr = eeprom_addr;
         wr_data = eeprom_wdata;
         wr_mask = 32'hFFFF_FFFF;
      end else begin
         wr_addr = aw_addr_reg;
         wr_data = w_data_reg;
         wr_mask = strb_mask(w_strb_reg);
      end
   end

   assign wr_sel = decode_reg(wr_addr);
   assign ar_sel = decode_reg(s_axi_araddr);
   assign entry_wr_en = wr_go && (wr_sel == budget_pkg::RS_ENTRY);

   // Write channel
   assign aw_held_next = aw_fire ? 1'b1 : (bus_wr_go ? 1'b0 : aw_held_reg);
   assign w_held_next = w_fire ? 1'b1 : (bus_wr_go ? 1'b0 : w_held_reg);

   always_comb begin
      case (wr_state_reg)
         budget_pkg::WR_COLLECT: begin
            wr_state_next = bus_wr_go ? budget_pkg::WR_RESP : budget_pkg::WR_COLLECT;
         end
         budget_pkg::WR_RESP: begin
            wr_state_next = b_fire ? budget_pkg::WR_COLLECT : budget_pkg::WR_RESP;
         end
         default: begin
            wr_state_next = budget_pkg::WR_COLLECT;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= budget_pkg::WR_COLLECT;
         bvalid_reg <= 1'b0;
      end else begin
         wr_state_reg <= wr_state_next;
         bvalid_reg <= (wr_state_next == budget_pkg::WR_RESP);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= !aw_held_next && (wr_state_next == budget_pkg::WR_COLLECT);
         wready_reg <= !w_held_next && (wr_state_next == budget_pkg::WR_COLLECT);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         if (aw_fire) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_reg <= budget_pkg::RESP_OKAY;
      end else if (bus_wr_go) begin
         bresp_reg <= (wr_sel == budget_pkg::RS_NONE) ?
                      budget_pkg::RESP_SLVERR : budget_pkg::RESP_OKAY;
      end
   end

   // Capability header
   assign header_word = {nxt_ptr_reg, capability_version_reg, capability_identifier_reg};
   assign hdr_merged = merge_word(header_word, wr_data, wr_mask);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capability_identifier_reg <= budget_pkg::CAPABILITY_IDENTIFIER_RESET;
         capability_version_reg <= budget_pkg::CAPABILITY_VERSION_RESET;
         nxt_ptr_reg <= NEXT_PTR_RESET;
      end else if (wr_go && lock_ok && (wr_sel == budget_pkg::RS_HEADER)) begin
         capability_identifier_reg <= hdr_merged[budget_pkg::CAPABILITY_IDENTIFIER_LSB +: budget_pkg::CAPABILITY_IDENTIFIER_W];
         capability_version_reg <= hdr_merged[budget_pkg::CAPABILITY_VERSION_LSB +: budget_pkg::CAPABILITY_VERSION_W];
         nxt_ptr_reg <= hdr_merged[budget_pkg::NXT_LSB +: budget_pkg::NXT_W];
      end
   end

   // Entry selector, never locked
   assign select_word = {24'h00_0000, sel_reg};
   assign sel_merged = merge_word(select_word, wr_data, wr_mask);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_reg <= budget_pkg::SEL_RESET;
      end else if (wr_go && (wr_sel == budget_pkg::RS_SELECT)) begin
         sel_reg <= sel_merged[budget_pkg::SEL_W-1:0];
      end
   end

   // System allocated flag
   assign flags_word = {31'h0000_0000, sa_reg};
   assign flags_merged = merge_word(flags_word, wr_data, wr_mask);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sa_reg <= budget_pkg::SA_RESET;
      end else if (wr_go && lock_ok && (wr_sel == budget_pkg::RS_FLAGS)) begin
         sa_reg <= flags_merged[budget_pkg::SA_BIT];
      end
   end

   // Switch control: entry unlock and a lock that holds until reset
   assign switch_control_register_word = {30'h0000_0000, lock_reg, unlock_reg};
   assign switch_control_register_merged = merge_word(switch_control_register_word, wr_data, wr_mask);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unlock_reg <= budget_pkg::UNLOCK_RESET;
         lock_reg <= budget_pkg::LOCK_RESET;
      end else if (wr_go && (wr_sel == budget_pkg::RS_SWITCH_CONTROL_REGISTER)) begin
         unlock_reg <= switch_control_register_merged[budget_pkg::UNLOCK_BIT];
         lock_reg <= lock_reg | (wr_data[budget_pkg::LOCK_BIT] &
                                 wr_mask[budget_pkg::LOCK_BIT]);
      end
   end

   budget_entry_bank #(
      .ENTRIES(budget_pkg::ENTRY_COUNT),
      .IDX_W(budget_pkg::ENTRY_IDX_W),
      .DATA_W(budget_pkg::DATA_W)
   ) u_entries (
      .clk(aclk),
      .wr_en(entry_wr_en),
      .unlock(unlock_reg),
      .wr_idx(wr_addr[4:2]),
      .wr_data(wr_data),
      .wr_mask(wr_mask),
      .sel_idx(sel_reg[2:0]),
      .sel_data(win_data),
      .rd_idx(s_axi_araddr[4:2]),
      .rd_data(entry_rd_data)
   );

   // Window hides stored data when the selector is out of range
   assign window_word = (sel_reg > budget_pkg::SEL_MAX) ? 32'h0000_0000 : win_data;

   always_comb begin
      case (ar_sel)
         budget_pkg::RS_HEADER: rd_word = header_word;
         budget_pkg::RS_SELECT: rd_word = select_word;
         budget_pkg::RS_WINDOW: rd_word = window_word;
         budget_pkg::RS_FLAGS: rd_word = flags_word;
         budget_pkg::RS_SWITCH_CONTROL_REGISTER: rd_word = switch_control_register_word;
         budget_pkg::RS_ENTRY: rd_word = entry_rd_data;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Read channel
   always_comb begin
      case (rd_state_reg)
         budget_pkg::RD_IDLE: begin
            rd_state_next = ar_fire ? budget_pkg::RD_RESP : budget_pkg::RD_IDLE;
         end
         budget_pkg::RD_RESP: begin
            rd_state_next = r_fire ? budget_pkg::RD_IDLE : budget_pkg::RD_RESP;
         end
         default: begin
            rd_state_next = budget_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= budget_pkg::RD_IDLE;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
      end else begin
         rd_state_reg <= rd_state_next;
         arready_reg <= (rd_state_next == budget_pkg::RD_IDLE);
         rvalid_reg <= (rd_state_next == budget_pkg::RD_RESP);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= budget_pkg::RESP_OKAY;
      end else if (ar_fire) begin
         rdata_reg <= rd_word;
         rresp_reg <= (ar_sel == budget_pkg::RS_NONE) ?
                      budget_pkg::RESP_SLVERR : budget_pkg::RESP_OKAY;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   hdr_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> capability_identifier_reg == budget_pkg::CAPABILITY_IDENTIFIER_RESET &&
                         capability_version_reg == budget_pkg::CAPABILITY_VERSION_RESET && !sa_reg)
      else $error("header not cleared by reset");
   nxt_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> nxt_ptr_reg == NEXT_PTR_RESET)
      else $error("next pointer reset wrong");
   hdr_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && lock_ok && wr_sel == budget_pkg::RS_HEADER
      |=> header_word == $past(hdr_merged))
      else $error("header write not stored");
   hdr_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
      lock_reg && !eeprom_wr_en |=> $stable(header_word) && $stable(sa_reg))
      else $error("locked field changed");
   sel_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wr_sel == budget_pkg::RS_SELECT && wr_mask[0]
      |=> {24'h00_0000, sel_reg} == ($past(wr_data) & 32'h0000_00FF))
      else $error("selector write lost");
   sa_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && lock_ok && wr_sel == budget_pkg::RS_FLAGS && wr_mask[0]
      |=> {31'h0000_0000, sa_reg} == ($past(wr_data) & 32'h0000_0001))
      else $error("system allocated write lost");
   window_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && ar_sel == budget_pkg::RS_WINDOW && sel_reg > budget_pkg::SEL_MAX
      |=> rvalid_reg && rdata_reg == 32'h0000_0000)
      else $error("out of range window not zero");
   window_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && ar_sel == budget_pkg::RS_WINDOW && sel_reg <= budget_pkg::SEL_MAX
      |=> rdata_reg == $past(win_data))
      else $error("window shows wrong entry");
   entry_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && ar_sel == budget_pkg::RS_ENTRY
      |=> rdata_reg == $past(entry_rd_data) && rresp_reg == budget_pkg::RESP_OKAY)
      else $error("entry read wrong");
   reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && (ar_sel == budget_pkg::RS_SELECT || ar_sel == budget_pkg::RS_FLAGS)
      |=> rdata_reg[31:8] == 24'h00_0000 &&
          ($past(ar_sel) != budget_pkg::RS_FLAGS || rdata_reg[7:1] == 7'h00))
      else $error("reserved bits not zero");
   entry_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      entry_wr_en && !unlock_reg |=> $stable(win_data))
      else $error("locked entry write changed window");
endmodule

// File: shared/budget_pkg.sv
// Constants and types for the power budgeting capability registers
package budget_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int ENTRY_COUNT = 8;
   localparam int ENTRY_IDX_W = 3;

   localparam logic [11:0] HEADER_OFFSET = 12'h280;
   localparam logic [11:0] SELECT_OFFSET = 12'h284;
   localparam logic [11:0] WINDOW_OFFSET = 12'h288;
   localparam logic [11:0] FLAGS_OFFSET = 12'h28C;
   localparam logic [11:0] SWITCH_CONTROL_REGISTER_OFFSET = 12'h290;
   localparam logic [11:0] ENTRY_BASE = 12'h300;
   localparam logic [11:0] ENTRY_LAST = 12'h31C;

   localparam int CAPABILITY_IDENTIFIER_LSB = 0;
   localparam int CAPABILITY_IDENTIFIER_W = 16;
   localparam int CAPABILITY_VERSION_LSB = 16;
   localparam int CAPABILITY_VERSION_W = 4;
   localparam int NXT_LSB = 20;
   localparam int NXT_W = 12;
   localparam int SEL_W = 8;
   localparam int SA_BIT = 0;
   localparam int UNLOCK_BIT = 0;
   localparam int LOCK_BIT = 1;

   localparam logic [15:0] CAPABILITY_IDENTIFIER_RESET = 16'h0000;
   localparam logic [3:0] CAPABILITY_VERSION_RESET = 4'h0;
   localparam logic [11:0] NXT_END = 12'h000;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] SEL_MAX = 8'h07;
   localparam logic SA_RESET = 1'b0;
   localparam logic UNLOCK_RESET = 1'b0;
   localparam logic LOCK_RESET = 1'b0;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [5:0] {
      RS_NONE = 6'b000000,
      RS_HEADER = 6'b000001,
      RS_SELECT = 6'b000010,
      RS_WINDOW = 6'b000100,
      RS_FLAGS = 6'b001000,
      RS_SWITCH_CONTROL_REGISTER = 6'b010000,
      RS_ENTRY = 6'b100000
   } reg_sel_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_t;
endpackage

// File: core/budget_entry_bank.sv
// Sticky budget data entries with unlock-gated writes
`timescale 1ns/10ps
module budget_entry_bank #(
   parameter int ENTRIES = 8, // Number of entries
   parameter int IDX_W = 3, // Entry index width
   parameter int DATA_W = 32 // Entry width
) (
   input wire logic clk, // Clock
   input wire logic wr_en, // Write request
   input wire logic unlock, // Entry unlock level
   input wire logic [IDX_W-1:0] wr_idx, // Written entry
   input wire logic [DATA_W-1:0] wr_data, // Write data
   input wire logic [DATA_W-1:0] wr_mask, // Bit enables
   input wire logic [IDX_W-1:0] sel_idx, // Window entry
   output logic [DATA_W-1:0] sel_data, // Window contents
   input wire logic [IDX_W-1:0] rd_idx, // Direct read entry
   output logic [DATA_W-1:0] rd_data // Direct read contents
);
   // No reset: contents survive a reset
   logic [ENTRIES-1:0][DATA_W-1:0] entry_mem;
   logic [DATA_W-1:0] wr_merged;

   assign wr_merged = (entry_mem[wr_idx] & ~wr_mask) | (wr_data & wr_mask);

   always_ff @(posedge clk) begin
      if (wr_en && unlock) begin
         entry_mem[wr_idx] <= wr_merged;
      end
   end

   assign sel_data = entry_mem[sel_idx];
   assign rd_data = entry_mem[rd_idx];

   entry_locked_a: assert property (@(posedge clk)
      !unlock |=> $stable(entry_mem))
      else $error("entry changed while locked");

   entry_write_a: assert property (@(posedge clk)
      wr_en && unlock |=> entry_mem[$past(wr_idx)] == $past(wr_merged))
      else $error("unlocked entry write lost");
endmodule

// File: sim/power_budget_capability_regs_test.sv
// Self-checking bench for the power budgeting capability register bank
`timescale 1ns/10ps
module power_budget_capability_regs_test;
   localparam logic [1:0] OK = budget_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = budget_pkg::RESP_SLVERR;
   localparam logic [11:0] HDR = budget_pkg::HEADER_OFFSET;
   localparam logic [11:0] SEL = budget_pkg::SELECT_OFFSET;
   localparam logic [11:0] WIN = budget_pkg::WINDOW_OFFSET;
   localparam logic [11:0] FLG = budget_pkg::FLAGS_OFFSET;
   localparam logic [11:0] CTL = budget_pkg::SWITCH_CONTROL_REGISTER_OFFSET;
   localparam logic [11:0] ENT = budget_pkg::ENTRY_BASE;
   logic aclk, aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr, eeprom_addr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, eeprom_wr_en;
   logic [31:0] s_axi_wdata, s_axi_rdata, eeprom_wdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   power_budget_capability_regs dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .eeprom_wr_en(eeprom_wr_en),
      .eeprom_addr(eeprom_addr), .eeprom_wdata(eeprom_wdata)
   );

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic wrap_up;
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Hang guard: far above the few hundred cycles the sequence needs
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic [31:0] pat(input int i, input logic [7:0] s);
      return {s, 8'(i), ~s, ~8'(i)};
   endfunction

   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (1) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) break;
      end
      chk($sformatf("bresp@%h", a), 32'(er), 32'(s_axi_bresp));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ar_ok;
      ar_ok = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (1) begin
         @(posedge aclk);
         if (!ar_ok && s_axi_arready) begin
            ar_ok = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid) break;
      end
      chk($sformatf("rdata@%h", a), e, s_axi_rdata);
      chk($sformatf("rresp@%h", a), 32'(er), 32'(s_axi_rresp));
   endtask

   // Serial loader word write, visible the cycle after
   task automatic load(input logic [11:0] a, input logic [31:0] v);
      eeprom_wr_en <= 1'b1;
      eeprom_addr <= a;
      eeprom_wdata <= v;
      @(posedge aclk);
      eeprom_wr_en <= 1'b0;
      @(posedge aclk);
   endtask

   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 12'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      eeprom_wr_en = 1'b0;
      eeprom_addr = 12'h000;
      eeprom_wdata = 32'h0000_0000;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(HDR, 32'h0000_0000, OK);
      rd(SEL, 32'h0000_0000, OK);
      rd(FLG, 32'h0000_0000, OK);
      wr(HDR, 32'h2A01_0004, OK);
      rd(HDR, 32'h2A01_0004, OK);
      wr(SEL, 32'hFFFF_FF05, OK);
      rd(SEL, 32'h0000_0005, OK);
      wr(FLG, 32'hFFFF_FFFF, OK);
      rd(FLG, 32'h0000_0001, OK);
      // Unlocked: fill every entry, then read directly and through the window
      wr(CTL, 32'h0000_0001, OK);
      for (int i = 0; i < 8; i++) wr(ENT + 12'(4 * i), pat(i, 8'hA5), OK);
      for (int i = 0; i < 8; i++) begin
         rd(ENT + 12'(4 * i), pat(i, 8'hA5), OK);
         wr(SEL, 32'(i), OK);
         rd(WIN, pat(i, 8'hA5), OK);
      end
      wr(SEL, 32'h0000_0008, OK);
      rd(WIN, 32'h0000_0000, OK);
      wr(SEL, 32'h0000_00FF, OK);
      rd(WIN, 32'h0000_0000, OK);
      wr(SEL, 32'h0000_0002, OK);
      wr(WIN, 32'hDEAD_BEEF, OK);
      rd(WIN, pat(2, 8'hA5), OK);
      // Locked entries: bus and loader writes are dropped
      wr(CTL, 32'h0000_0000, OK);
      for (int i = 0; i < 8; i++) wr(ENT + 12'(4 * i), pat(i, 8'h3C), OK);
      load(ENT, 32'h1234_5678);
      for (int i = 0; i < 8; i++) rd(ENT + 12'(4 * i), pat(i, 8'hA5), OK);
      // Lock engaged: bus writes to lockable fields dropped, loader still lands
      wr(CTL, 32'h0000_0002, OK);
      rd(CTL, 32'h0000_0002, OK);
      wr(HDR, 32'h1234_5678, OK);
      rd(HDR, 32'h2A01_0004, OK);
      wr(FLG, 32'h0000_0000, OK);
      rd(FLG, 32'h0000_0001, OK);
      wr(SEL, 32'h0000_0003, OK);
      rd(SEL, 32'h0000_0003, OK);
      load(HDR, 32'h0011_0004);
      rd(HDR, 32'h0011_0004, OK);
      load(FLG, 32'h0000_0000);
      rd(FLG, 32'h0000_0000, OK);
      wr(CTL, 32'h0000_0003, OK);
      load(ENT + 12'h014, pat(5, 8'h77));
      rd(ENT + 12'h014, pat(5, 8'h77), OK);
      wr(ENT + 12'h01C, pat(7, 8'h77), OK);
      rd(ENT + 12'h01C, pat(7, 8'h77), OK);
      wr(SEL, 32'h0000_0007, OK);
      rd(WIN, pat(7, 8'h77), OK);
      // Unmapped places answer with an error and no data
      wr(12'h320, 32'hFFFF_FFFF, ERR);
      rd(12'h320, 32'h0000_0000, ERR);
      wr(12'h400, 32'hFFFF_FFFF, ERR);
      rd(12'h400, 32'h0000_0000, ERR);
      rd(ENT, pat(0, 8'hA5), OK);
      wrap_up();
   end
endmodule
